// file: verilog/xcvr_channel.sv
// One transceiver channel: mode, thermal shutdown, dominant timeout, wake-up filter
`timescale 1ns/100ps
`include "xcvr_ctrl_regs.svh"
module xcvr_channel
  import xcvr_ctrl_pkg::*;
#(
  parameter int unsigned FLT1_CYC = `WU_FLT1_CYC,
  parameter int unsigned FLT2_CYC = `WU_FLT2_CYC,
  parameter int unsigned WU_TO_CYC = `WU_TO_CYC,
  parameter int unsigned XDOM_CYC = `XDOM_CYC,
  parameter int unsigned CW = 17
) (
  input  wire logic clk,                     // 100 MHz clock
  input  wire logic rst,                     // Async reset, active high
  input  wire logic channel_standby_select,  // High selects standby
  input  wire logic channel_transmit_in,     // Low requests dominant
  input  wire logic bus_dominant,            // Bus state from receiver
  input  wire logic ot_hot,                  // Synced: above shutdown limit
  input  wire logic ot_cool,                 // Synced: below limit minus hysteresis
  input  wire logic core_uv,                 // Synced core undervoltage
  input  wire logic io_uv,                   // Synced I/O undervoltage
  output logic      drive_dominant,          // Driver on, bus dominant
  output logic      bias_enable,             // Bus biasing on
  output logic      bus_hiz,                 // Bus pins high impedance
  output logic      channel_receive_out,     // Receive data level
  output logic      rx_drive_en,             // Receive push-pull enabled
  output logic      wake_seen                // Wake-up recognized
);
  typedef struct packed {
    wake_state_e wst;
    logic [CW-1:0] fcnt;
    logic [CW-1:0] tcnt;
    logic [CW-1:0] dcnt;
    logic        ot_off;
    logic        dom_off;
    logic        tx_prev;
    logic        woke;
    logic        drv;
    logic        rxd;
    logic [1:0]  mode;
  } st_s;

  st_s q, d;
  chan_mode_e mode_now;
  logic       tx_fall;

  always_comb begin
    if (io_uv) mode_now = MODE_OFF;
    else if (core_uv || channel_standby_select) mode_now = MODE_STANDBY;
    else mode_now = MODE_NORMAL;
  end

  assign tx_fall = q.tx_prev && !channel_transmit_in;

  always_comb begin
    d = q;
    d.tx_prev = channel_transmit_in;
    d.mode = mode_now;
    if (ot_hot) d.ot_off = 1'b1;
    else if (ot_cool && tx_fall) d.ot_off = 1'b0;
    if (channel_transmit_in) begin
      d.dcnt = '0;
      d.dom_off = 1'b0;
    end else if (q.dcnt >= CW'(XDOM_CYC - 1)) begin
      d.dom_off = 1'b1;
    end else begin
      d.dcnt = q.dcnt + 1'b1;
    end
    d.fcnt = q.fcnt + 1'b1;
    d.tcnt = q.tcnt + 1'b1;
    if (mode_now != MODE_STANDBY) begin
      d.wst = WU_IDLE;
      d.woke = 1'b0;
      d.fcnt = '0;
      d.tcnt = '0;
    end else if (!q.woke) begin
      if (q.wst != WU_IDLE && q.tcnt >= CW'(WU_TO_CYC - 1)) begin
        d.wst = WU_IDLE;
        d.fcnt = '0;
      end else begin
        case (q.wst)
          WU_IDLE: begin
            d.fcnt = '0;
            d.tcnt = '0;
            if (bus_dominant) d.wst = WU_DOM1;
          end
          WU_DOM1: begin
            if (!bus_dominant) begin
              d.fcnt = '0;
              d.wst = (q.fcnt >= CW'(FLT1_CYC)) ? WU_REC : WU_IDLE;
            end
          end
          WU_REC: begin
            if (bus_dominant) begin
              d.fcnt = '0;
              d.wst = (q.fcnt >= CW'(FLT2_CYC)) ? WU_DOM2 : WU_DOM1;
            end
          end
          WU_DOM2: begin
            if (!bus_dominant) begin
              d.fcnt = '0;
              d.wst = WU_REC;
            end else if (q.fcnt >= CW'(FLT2_CYC)) begin
              d.woke = 1'b1;
              d.wst = WU_IDLE;
            end
          end
          default: d.wst = WU_IDLE;
        endcase
      end
    end
    d.drv = (mode_now == MODE_NORMAL) && !channel_transmit_in && !d.ot_off && !d.dom_off;
    case (mode_now)
      MODE_NORMAL:  d.rxd = !bus_dominant;
      MODE_STANDBY: d.rxd = d.woke ? !bus_dominant : 1'b1;
      default:      d.rxd = 1'b1;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{wst: WU_IDLE, mode: 2'(MODE_OFF), tx_prev: 1'b1, rxd: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign drive_dominant      = q.drv;
  assign bias_enable         = (q.mode == 2'(MODE_NORMAL));
  assign bus_hiz             = (q.mode == 2'(MODE_OFF));
  assign channel_receive_out = q.rxd;
  assign rx_drive_en         = (q.mode == 2'(MODE_NORMAL)) || ((q.mode == 2'(MODE_STANDBY)) && q.woke);
  assign wake_seen           = q.woke;

  a_ot_driver_off: assert property (@(posedge clk) disable iff (rst) ot_hot |=> !drive_dominant)
    else $error("driver on while hot");
  a_ot_warm_hold: assert property (@(posedge clk) disable iff (rst)
    (q.ot_off && !ot_cool) |=> q.ot_off)
    else $error("thermal shutdown left while warm");
  a_ot_need_edge: assert property (@(posedge clk) disable iff (rst)
    ($fell(q.ot_off)) |-> $past(channel_transmit_in, 2) && !$past(channel_transmit_in))
    else $error("shutdown cleared without own falling edge");
  a_uv_forces_stby: assert property (@(posedge clk) disable iff (rst)
    (core_uv && !io_uv) |=> (q.mode == 2'(MODE_STANDBY)) && !drive_dominant)
    else $error("core undervoltage did not force standby");
  a_io_uv_silent: assert property (@(posedge clk) disable iff (rst)
    io_uv |=> bus_hiz && !drive_dominant && channel_receive_out && !wake_seen)
    else $error("activity while unpowered");
  a_normal_tx_path: assert property (@(posedge clk) disable iff (rst)
    (mode_now == MODE_NORMAL && !ot_hot && !q.ot_off && channel_transmit_in) |=> !drive_dominant)
    else $error("recessive transmit drove bus");
  a_normal_rx_path: assert property (@(posedge clk) disable iff (rst)
    (mode_now == MODE_NORMAL) |=> channel_receive_out == !$past(bus_dominant))
    else $error("receive does not follow bus");
  a_stby_rx_high: assert property (@(posedge clk) disable iff (rst)
    (mode_now == MODE_STANDBY && !q.woke && !d.woke) |=> channel_receive_out && !drive_dominant)
    else $error("standby receive not held high");
  a_wake_needs_time: assert property (@(posedge clk) disable iff (rst)
    $rose(wake_seen) |-> $past(bus_dominant))
    else $error("wake without final dominant phase");
  a_dom_timeout: assert property (@(posedge clk) disable iff (rst)
    q.dom_off |-> !drive_dominant)
    else $error("driver on after dominant timeout");

  c_wake: cover property (@(posedge clk) disable iff (rst) $rose(wake_seen));
  c_ot_recover: cover property (@(posedge clk) disable iff (rst) $fell(q.ot_off));
  c_dom_timeout: cover property (@(posedge clk) disable iff (rst) $rose(q.dom_off));
  c_normal_tx: cover property (@(posedge clk) disable iff (rst) $rose(drive_dominant));
endmodule

// file: verilog/xcvr_ctrl_regs.svh
// Timing constants for the dual transceiver control logic
`ifndef XCVR_CTRL_REGS_SVH
`define XCVR_CTRL_REGS_SVH

`define CLK_PERIOD_NS        10
`define WU_FLT1_NS           500
`define WU_FLT2_NS           500
`define WU_TO_NS             1000000
`define XDOM_NS              1000000
`define WU_FLT1_CYC          ((`WU_FLT1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WU_FLT2_CYC          ((`WU_FLT2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WU_TO_CYC            (`WU_TO_NS / `CLK_PERIOD_NS)
`define XDOM_CYC             ((`XDOM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: verilog/xcvr_ctrl_pkg.sv
// Types shared by the transceiver control logic
package xcvr_ctrl_pkg;
  typedef enum logic [1:0] {WU_IDLE, WU_DOM1, WU_REC, WU_DOM2} wake_state_e;
  typedef enum logic [1:0] {MODE_OFF, MODE_STANDBY, MODE_NORMAL} chan_mode_e;
endpackage

// file: verilog/dual_xcvr_ctrl.sv
// Top: two independent channels with shared synchronized supply monitors
`timescale 1ns/100ps
`include "xcvr_ctrl_regs.svh"
module dual_xcvr_ctrl
  import xcvr_ctrl_pkg::*;
#(
  parameter int unsigned WU_TO_CYC = `WU_TO_CYC,
  parameter int unsigned XDOM_CYC  = `XDOM_CYC
) (
  input  wire logic       clk,                      // 100 MHz clock
  input  wire logic       rst,                      // Async reset, active high
  input  wire logic [1:0] channel_standby_select,   // Per channel, high = standby
  input  wire logic [1:0] channel_transmit_in,      // Per channel transmit data
  input  wire logic [1:0] bus_dominant,             // Per channel bus receiver state
  input  wire logic [1:0] thermal_shutdown_limit,   // Async: above shutdown limit
  input  wire logic [1:0] thermal_below_hyst,       // Async: below limit minus hysteresis
  input  wire logic       core_supply_undervoltage, // Async core comparator
  input  wire logic       io_supply_undervoltage,   // Async I/O comparator
  output logic      [1:0] bus_high_line_drive,      // High line driven dominant
  output logic      [1:0] bus_low_line_drive,       // Low line driven dominant
  output logic      [1:0] bus_bias_enable,          // Biasing on
  output logic      [1:0] bus_hiz,                  // Bus pins high impedance
  output logic      [1:0] channel_receive_out,      // Receive data
  output logic      [1:0] channel_receive_oe,       // Receive push-pull enable
  output logic      [1:0] wake_seen                 // Wake-up recognized
);
  // Comparators are asynchronous; two-stage synchronizers, first stage read only by second
  logic [5:0] s1_q, s2_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 6'h30;
      s2_q <= 6'h30;
    end else begin
      s1_q <= {io_supply_undervoltage, core_supply_undervoltage,
               thermal_below_hyst, thermal_shutdown_limit};
      s2_q <= s1_q;
    end
  end

  logic [1:0] drv;
  for (genvar i = 0; i < 2; i++) begin : g_ch
    xcvr_channel #(.WU_TO_CYC(WU_TO_CYC), .XDOM_CYC(XDOM_CYC)) u_ch (
      .clk                    (clk),
      .rst                    (rst),
      .channel_standby_select (channel_standby_select[i]),
      .channel_transmit_in    (channel_transmit_in[i]),
      .bus_dominant           (bus_dominant[i]),
      .ot_hot                 (s2_q[i]),
      .ot_cool                (s2_q[2+i]),
      .core_uv                (s2_q[4]),
      .io_uv                  (s2_q[5]),
      .drive_dominant         (drv[i]),
      .bias_enable            (bus_bias_enable[i]),
      .bus_hiz                (bus_hiz[i]),
      .channel_receive_out    (channel_receive_out[i]),
      .rx_drive_en            (channel_receive_oe[i]),
      .wake_seen              (wake_seen[i])
    );
  end

  assign bus_high_line_drive = drv;
  assign bus_low_line_drive  = drv;
endmodule

// file: verification/can_ctrl_model.sv
// Behavioural model of the protocol controller that drives both channels
`timescale 1ns/100ps
module can_ctrl_model (
  input  wire logic       clk,          // Bench clock
  output logic      [1:0] standby_sel,  // Mode select per channel, high = standby
  output logic      [1:0] transmit      // Transmit data per channel, low = dominant
);
  initial begin
    standby_sel = 2'h3;
    transmit    = 2'h3;
  end
  task automatic set_mode(input int ch, input logic stby);
    @(posedge clk);
    standby_sel[ch] <= stby;
  endtask
  task automatic send(input int ch, input logic lvl);
    @(posedge clk);
    transmit[ch] <= lvl;
  endtask
  // Always passes through high first, so a shut-down driver sees a clean falling edge
  task automatic restart(input int ch);
    send(ch, 1'b1);
    send(ch, 1'b0);
  endtask
endmodule

// file: verification/dual_xcvr_ctrl_tb.sv
// Self-checking bench for the dual transceiver mode and fault control
`timescale 1ns/100ps
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED %s expected %b seen %b", what, exp, got); end end
module dual_xcvr_ctrl_tb;
  logic       clk = 1'b0;
  logic       rst;
  logic [1:0] bus_dom;
  logic [1:0] hot;
  logic [1:0] cool;
  logic       core_uv;
  logic       io_uv;
  logic [1:0] stby, tx, hi_drv, lo_drv, bias, hiz, rx, rx_oe, wake;
  int         fail_count = 0;
  int         comparisons = 0;
  int         cycles = 0;

  always #5 clk = ~clk;

  can_ctrl_model u_can_ctrl_model (.clk(clk), .standby_sel(stby), .transmit(tx));

  // Short timeouts keep the run brief; expectations below are derived from them
  dual_xcvr_ctrl #(.WU_TO_CYC(400), .XDOM_CYC(200)) u_dual_xcvr_ctrl (
    .clk(clk), .rst(rst), .channel_standby_select(stby), .channel_transmit_in(tx),
    .bus_dominant(bus_dom), .thermal_shutdown_limit(hot), .thermal_below_hyst(cool),
    .core_supply_undervoltage(core_uv), .io_supply_undervoltage(io_uv),
    .bus_high_line_drive(hi_drv), .bus_low_line_drive(lo_drv), .bus_bias_enable(bias),
    .bus_hiz(hiz), .channel_receive_out(rx), .channel_receive_oe(rx_oe), .wake_seen(wake));

  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_bus(input int ch, input logic v);
    @(posedge clk);
    bus_dom[ch] <= v;
  endtask
  task automatic set_temp(input int ch, input logic h, input logic c);
    @(posedge clk);
    hot[ch]  <= h;
    cool[ch] <= c;
  endtask
  // Dominant, recessive, dominant: each phase beyond the 50-cycle filters, all well inside 400
  task automatic wake_pattern(input int ch);
    set_bus(ch, 1'b1);
    wait_cyc(60);
    set_bus(ch, 1'b0);
    wait_cyc(60);
    set_bus(ch, 1'b1);
    wait_cyc(60);
  endtask

  task automatic test_normal();
    u_can_ctrl_model.set_mode(0, 1'b0);
    u_can_ctrl_model.set_mode(1, 1'b0);
    u_can_ctrl_model.send(0, 1'b0);
    wait_cyc(2);
    `CHK("high drive ch0", 1'b1, hi_drv[0])
    `CHK("low drive ch0", 1'b1, lo_drv[0])
    `CHK("bias ch0", 1'b1, bias[0])
    `CHK("drive ch1 recessive", 1'b0, hi_drv[1])
    set_bus(0, 1'b1);
    wait_cyc(2);
    `CHK("receive dominant", 1'b0, rx[0])
    `CHK("wake in normal", 1'b0, wake[0])
    set_bus(0, 1'b0);
    u_can_ctrl_model.send(0, 1'b1);
    wait_cyc(2);
    `CHK("receive recessive", 1'b1, rx[0])
    `CHK("drive released", 1'b0, hi_drv[0])
  endtask

  task automatic test_thermal();
    u_can_ctrl_model.send(0, 1'b0);
    u_can_ctrl_model.send(1, 1'b0);
    set_temp(0, 1'b1, 1'b0);
    wait_cyc(5);
    `CHK("hot ch0 driver off", 1'b0, lo_drv[0])
    `CHK("cool ch1 driver on", 1'b1, lo_drv[1])
    set_temp(0, 1'b0, 1'b0);
    u_can_ctrl_model.restart(0);
    wait_cyc(5);
    `CHK("edge while warm", 1'b0, lo_drv[0])
    set_temp(0, 1'b0, 1'b1);
    wait_cyc(5);
    `CHK("cool without edge", 1'b0, lo_drv[0])
    u_can_ctrl_model.restart(1);
    wait_cyc(3);
    `CHK("edge on other channel", 1'b0, lo_drv[0])
    u_can_ctrl_model.restart(0);
    wait_cyc(2);
    `CHK("cool and edge", 1'b1, lo_drv[0])
    set_temp(1, 1'b1, 1'b0);
    wait_cyc(5);
    `CHK("hot ch1 driver off", 1'b0, lo_drv[1])
    `CHK("ch0 unaffected by ch1 heat", 1'b1, lo_drv[0])
    set_temp(1, 1'b0, 1'b1);
    wait_cyc(3);
    u_can_ctrl_model.restart(1);
    wait_cyc(2);
    `CHK("ch1 cool and own edge", 1'b1, lo_drv[1])
    u_can_ctrl_model.send(0, 1'b1);
    u_can_ctrl_model.send(1, 1'b1);
  endtask

  task automatic test_dom_timeout();
    u_can_ctrl_model.send(0, 1'b0);
    wait_cyc(150);
    `CHK("before dominant timeout", 1'b1, hi_drv[0])
    wait_cyc(60);
    `CHK("after dominant timeout", 1'b0, hi_drv[0])
    u_can_ctrl_model.restart(0);
    wait_cyc(2);
    `CHK("recovered after high", 1'b1, hi_drv[0])
    u_can_ctrl_model.send(0, 1'b1);
  endtask

  task automatic test_standby_wake();
    u_can_ctrl_model.set_mode(0, 1'b1);
    u_can_ctrl_model.send(0, 1'b0);
    wait_cyc(2);
    `CHK("standby no drive", 1'b0, hi_drv[0])
    `CHK("standby no bias", 1'b0, bias[0])
    `CHK("standby oe off", 1'b0, rx_oe[0])
    u_can_ctrl_model.send(0, 1'b1);
    set_bus(0, 1'b1);
    wait_cyc(30);
    `CHK("receive held high", 1'b1, rx[0])
    wake_pattern(0);
    `CHK("wake recognized", 1'b1, wake[0])
    `CHK("oe after wake", 1'b1, rx_oe[0])
    `CHK("toggle dominant", 1'b0, rx[0])
    set_bus(0, 1'b0);
    wait_cyc(2);
    `CHK("toggle recessive", 1'b1, rx[0])
  endtask

  // Slow pattern overruns the 400-cycle window, then the bus sticks dominant
  task automatic test_perm_dom();
    u_can_ctrl_model.set_mode(1, 1'b1);
    set_bus(1, 1'b1);
    wait_cyc(350);
    set_bus(1, 1'b0);
    wait_cyc(60);
    set_bus(1, 1'b1);
    wait_cyc(500);
    `CHK("stuck dominant no wake", 1'b0, wake[1])
    `CHK("stuck dominant rx high", 1'b1, rx[1])
    set_bus(1, 1'b0);
  endtask

  task automatic test_supply();
    u_can_ctrl_model.set_mode(0, 1'b0);
    @(posedge clk);
    core_uv <= 1'b1;
    wait_cyc(5);
    u_can_ctrl_model.send(0, 1'b0);
    wait_cyc(2);
    `CHK("core loss no drive", 1'b0, hi_drv[0])
    `CHK("core loss no bias", 1'b0, bias[0])
    u_can_ctrl_model.send(0, 1'b1);
    wake_pattern(0);
    `CHK("wake under core loss", 1'b1, wake[0])
    set_bus(0, 1'b0);
    @(posedge clk);
    io_uv <= 1'b1;
    wait_cyc(5);
    `CHK("unpowered hiz", 2'h3, hiz)
    `CHK("unpowered bias", 2'h0, bias)
    wake_pattern(1);
    `CHK("unpowered no wake", 2'h0, wake)
    `CHK("unpowered no oe", 2'h0, rx_oe)
    `CHK("unpowered no receive", 2'h3, rx)
  endtask

  initial begin
    rst     = 1'b1;
    bus_dom = 2'h0;
    hot     = 2'h0;
    cool    = 2'h3;
    core_uv = 1'b0;
    io_uv   = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_cyc(3);
    test_normal();
    test_thermal();
    test_dom_timeout();
    test_standby_wake();
    test_perm_dom();
    test_supply();
    finish_test();
  end
endmodule
